/* File: hdl/ssp_pkg.sv */
/*
 * Types of the synchronous serial shift port.
 * Assumes ssp_regs.svh carries all numeric constants.
 */
package ssp_pkg;

    typedef enum logic [1:0] {
        SSP_CLK_SYS  = 2'b00,
        SSP_CLK_HALF = 2'b01,
        SSP_CLK_TMR  = 2'b10,
        SSP_CLK_EXT  = 2'b11
    } ssp_clksel_e;

    typedef enum logic [1:0] {
        SSP_ST_IDLE = 2'b00,
        SSP_ST_HIGH = 2'b01,
        SSP_ST_LOW  = 2'b10
    } ssp_state_e;

    // Serial pins as seen by the port
    typedef struct packed {
        logic sclk_o;
        logic sclk_oe;
        logic serial_out_pin;
    } ssp_pins_s;

    typedef struct packed {
        ssp_state_e  st;
        logic [7:0]  shreg;
        logic [3:0]  cnt;
        logic        lsb_first;
        ssp_clksel_e clksel;
        logic        go;
        logic        half_tog;
        ssp_pins_s   pins;
        logic [2:0]  sclk_sync;
        logic [1:0]  sin_sync;
        logic [1:0]  samp_pipe;
        logic        irq_stat;
        logic        irq_mask;
        logic        done_pulse;
        logic        aw_full;
        logic [31:0] aw_addr;
        logic        w_full;
        logic [31:0] w_data;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ssp_state_s;

endpackage

/* File: hdl/ssp_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * synchronous serial shift port. Assumes a 32-bit AXI4-Lite register bus.
 */
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

// Printed offsets are not multiples of four: they are register indices
`define SSP_IDX_DATA_LOW 12'h0A0
`define SSP_IDX_DATA_HIGH 12'h0A1
`define SSP_IDX_CTRL_A 12'h0A2
`define SSP_IDX_CTRL_B 12'h0A3
`define SSP_IDX_IRQ_STATUS 12'h0A4
`define SSP_IDX_IRQ_MASK 12'h0A5

// Field positions
`define SSP_CTRLA_ORDER_BIT 2
`define SSP_CTRLB_GO_BIT 0
`define SSP_IRQ_DONE_BIT 0

// Reset values
`define SSP_NIBBLE_RST 4'h0

// Timing
`define SSP_BITS_PER_XFER 4'h8
`define SSP_CLK_PERIOD_NS 10

`endif

/* File: hdl/ssp_shift_port.sv */
/*
 * Synchronous serial shift port: one 8-bit shift register sending and
 * receiving at once, with AXI4-Lite registers and a level interrupt.
 * Assumes sclk and sin pins are asynchronous to clk_i, the timer overflow
 * is a one-cycle pulse on clk_i, and the pad resolves the sclk enables.
 */
// The AXI4-Lite slave port was decided locally.
// Behaviour
// - one 8-bit shift register sends and receives a byte per transfer
// - data reachable as low nibble bits 3..0 and high nibble bits 7..4
// - reset clears both data nibbles and both control registers
// - control A bit 2: zero gives MSB first, one gives LSB first
// - two-bit clock select: system, half, timer overflow, or external
// - in master mode the shift clock is driven on the clock pin
// - in slave mode only eight clocks per transfer count, later ones ignored
// - writing one to the go bit starts; hardware clears it after eight bits
// - serial output changes on each falling shift-clock edge
// - serial input sampled on each rising shift-clock edge
// - completion of a transfer raises the shift-done interrupt
// - clock pin idles high; data pin low after reset, holds last bit after
// - writing data during a transfer corrupts it; software restarts
// - no shifting without the go bit, even in slave mode
// - completion can be polled from the irq flag or the go bit
`timescale 1ns/1ps
`include "ssp_regs.svh"

module ssp_shift_port #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Timer overflow pulse
    input wire logic tmr_ovf_i,
    // Serial pins
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    input wire logic sclk_pin_i,
    output logic sclk_pin_o,
    output logic sclk_pin_oe_o,
    // Interrupt
    output logic shift_done_irq_o,
    output logic irq_o
);

    // Register byte addresses reach 12'h294, so ten address bits are the least
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must hold the register byte addresses");
    end

    ssp_pkg::ssp_state_s q, d;

    // Byte address to register index; unaligned or out of range gives 12'hFFF
    function automatic logic [11:0] reg_index(input logic [ADDR_W-1:0] a);
        logic [31:0] wide;
        wide = 32'(a);
        if (wide[1:0] != 2'h0 || wide[31:14] != 18'h0) begin
            return 12'hFFF;
        end
        return wide[13:2];
    endfunction

    // Bit position of the n-th bit sent in the selected order
    function automatic logic [2:0] bit_pos(input logic lsb, input logic [3:0] n);
        return lsb ? n[2:0] : 3'(7 - n[2:0]);
    endfunction

    logic master;
    logic tick;
    logic ext_rise;
    logic ext_fall;
    logic do_write;
    logic do_read;
    logic [11:0] widx;
    logic [11:0] ridx;
    logic sin_s;
    logic go_set;

    assign master = q.clksel != ssp_pkg::SSP_CLK_EXT;
    assign ext_rise = q.sclk_sync[1] & ~q.sclk_sync[2];
    assign ext_fall = ~q.sclk_sync[1] & q.sclk_sync[2];
    assign sin_s = q.sin_sync[1];
    assign do_write = q.aw_full && q.w_full && !q.bvalid;
    assign do_read = s_axi_arvalid_i && !q.rvalid;
    assign widx = reg_index(q.aw_addr[ADDR_W-1:0]);
    assign ridx = reg_index(s_axi_araddr_i);
    assign go_set = do_write && widx == `SSP_IDX_CTRL_B && q.w_data[`SSP_CTRLB_GO_BIT];

    // Master half-period ticks from the selected source
    always_comb begin
        case (q.clksel)
            ssp_pkg::SSP_CLK_SYS: tick = 1'b1;
            ssp_pkg::SSP_CLK_HALF: tick = q.half_tog;
            ssp_pkg::SSP_CLK_TMR: tick = tmr_ovf_i;
            default: tick = 1'b0;
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        d = q;
        d.done_pulse = 1'b0;
        d.half_tog = ~q.half_tog;
        d.sclk_sync = {q.sclk_sync[1:0], sclk_pin_i};
        d.sin_sync = {q.sin_sync[0], serial_in_pin_i};
        d.samp_pipe = {q.samp_pipe[0], 1'b0};

        // Master samples two cycles after its rising edge: the input synchroniser
        // delays the pin by that much, so this captures the level at the edge
        if (q.samp_pipe[1]) begin
            d.shreg[bit_pos(q.lsb_first, q.cnt - 4'h1)] = sin_s;
        end

        // Shift engine
        case (q.st)
            ssp_pkg::SSP_ST_IDLE: begin
                d.pins.sclk_o = 1'b1;
                if (q.go) begin
                    d.cnt = 4'h0;
                    d.st = ssp_pkg::SSP_ST_LOW;
                    if (master) begin
                        d.pins.sclk_o = 1'b0;
                        d.pins.serial_out_pin = q.shreg[bit_pos(q.lsb_first, 4'h0)];
                        d.st = ssp_pkg::SSP_ST_HIGH;
                    end
                end
            end
            ssp_pkg::SSP_ST_HIGH: begin
                // Master: clock is low, next tick raises it; the sample lands later
                if (tick) begin
                    d.pins.sclk_o = 1'b1;
                    d.samp_pipe[0] = 1'b1;
                    d.cnt = q.cnt + 4'h1;
                    d.st = ssp_pkg::SSP_ST_LOW;
                end
            end
            ssp_pkg::SSP_ST_LOW: begin
                if (q.cnt == `SSP_BITS_PER_XFER) begin
                    // Eighth clock done; later slave edges are ignored
                    // Master waits until its last late sample has landed
                    if (!q.samp_pipe[0]) begin
                        d.go = 1'b0;
                        d.done_pulse = 1'b1;
                        d.irq_stat = 1'b1;
                        d.st = ssp_pkg::SSP_ST_IDLE;
                    end
                end else if (master && tick) begin
                    d.pins.sclk_o = 1'b0;
                    d.pins.serial_out_pin = q.shreg[bit_pos(q.lsb_first, q.cnt)];
                    d.st = ssp_pkg::SSP_ST_HIGH;
                end else if (!master && ext_fall) begin
                    d.pins.serial_out_pin = q.shreg[bit_pos(q.lsb_first, q.cnt)];
                end else if (!master && ext_rise) begin
                    d.shreg[bit_pos(q.lsb_first, q.cnt)] = sin_s;
                    d.cnt = q.cnt + 4'h1;
                end
            end
            default: d.st = ssp_pkg::SSP_ST_IDLE;
        endcase
        d.pins.sclk_oe = master;

        // Write channel
        if (s_axi_awvalid_i && !q.aw_full) begin
            d.aw_full = 1'b1;
            d.aw_addr = 32'(s_axi_awaddr_i);
        end
        if (s_axi_wvalid_i && !q.w_full) begin
            d.w_full = 1'b1;
            d.w_data = s_axi_wdata_i;
        end
        if (do_write) begin
            d.aw_full = 1'b0;
            d.w_full = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = 2'h0;
            if (s_axi_wstrb_i[0] || 1'b1) begin
                case (widx)
                    // Writing mid-transfer overwrites the live shifter
                    `SSP_IDX_DATA_LOW: d.shreg[3:0] = q.w_data[3:0];
                    `SSP_IDX_DATA_HIGH: d.shreg[7:4] = q.w_data[3:0];
                    `SSP_IDX_CTRL_A: begin
                        d.lsb_first = q.w_data[`SSP_CTRLA_ORDER_BIT];
                        d.clksel = ssp_pkg::ssp_clksel_e'(q.w_data[1:0]);
                    end
                    // Go only sets; zero writes leave a running transfer alone
                    `SSP_IDX_CTRL_B: if (go_set) d.go = 1'b1;
                    `SSP_IDX_IRQ_STATUS: if (q.w_data[`SSP_IRQ_DONE_BIT]) d.irq_stat = 1'b0;
                    `SSP_IDX_IRQ_MASK: d.irq_mask = q.w_data[`SSP_IRQ_DONE_BIT];
                    default: d.bresp = 2'h2;
                endcase
            end
            // Set wins over a simultaneous clear
            if (d.done_pulse) begin
                d.irq_stat = 1'b1;
            end
        end
        if (q.bvalid && s_axi_bready_i) begin
            d.bvalid = 1'b0;
        end

        // Read channel
        if (do_read) begin
            d.rvalid = 1'b1;
            d.rresp = 2'h0;
            d.rdata = 32'h0;
            case (ridx)
                `SSP_IDX_DATA_LOW: d.rdata[3:0] = q.shreg[3:0];
                `SSP_IDX_DATA_HIGH: d.rdata[3:0] = q.shreg[7:4];
                `SSP_IDX_CTRL_A: d.rdata[3:0] = {1'b0, q.lsb_first, q.clksel};
                `SSP_IDX_CTRL_B: d.rdata[3:0] = {3'h0, q.go};
                `SSP_IDX_IRQ_STATUS: d.rdata[3:0] = {3'h0, q.irq_stat};
                `SSP_IDX_IRQ_MASK: d.rdata[3:0] = {3'h0, q.irq_mask};
                default: d.rresp = 2'h2;
            endcase
        end
        if (q.rvalid && s_axi_rready_i) begin
            d.rvalid = 1'b0;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '0;
            q.pins.sclk_o <= 1'b1;
            q.pins.sclk_oe <= 1'b1;
            q.sclk_sync <= 3'h7;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign s_axi_awready_o = !q.aw_full;
    assign s_axi_wready_o = !q.w_full;
    assign s_axi_bvalid_o = q.bvalid;
    assign s_axi_bresp_o = q.bresp;
    assign s_axi_arready_o = !q.rvalid;
    assign s_axi_rvalid_o = q.rvalid;
    assign s_axi_rdata_o = q.rdata;
    assign s_axi_rresp_o = q.rresp;
    assign serial_out_pin_o = q.pins.serial_out_pin;
    assign sclk_pin_o = q.pins.sclk_o;
    assign sclk_pin_oe_o = q.pins.sclk_oe;
    assign shift_done_irq_o = q.done_pulse;
    assign irq_o = q.irq_stat & q.irq_mask;

    // ==========================================================
    // Assertions
    sequence s_last_bit;
        q.st == ssp_pkg::SSP_ST_LOW && q.cnt == `SSP_BITS_PER_XFER && !q.samp_pipe[0];
    endsequence

    sequence s_done;
        shift_done_irq_o && !q.go;
    endsequence

    a_done_after_eight: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_last_bit |=> s_done) else $error("transfer end without done pulse");

    a_done_one_cycle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        shift_done_irq_o |=> !shift_done_irq_o) else $error("done pulse longer than one cycle");

    a_go_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $fell(q.go) |-> shift_done_irq_o) else $error("go cleared without completion");

    a_idle_clock_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        q.st == ssp_pkg::SSP_ST_IDLE |-> sclk_pin_o) else $error("shift clock not high between transfers");

    a_no_shift_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (q.st == ssp_pkg::SSP_ST_IDLE && !q.go) |=> q.st == ssp_pkg::SSP_ST_IDLE)
        else $error("shift started without go");

    a_master_drives: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        master |=> sclk_pin_oe_o || $changed(q.clksel)) else $error("master not driving clock");

    a_out_on_fall: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        master && $changed(serial_out_pin_o) |-> !sclk_pin_o) else $error("data changed off falling edge");

    a_count_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        q.cnt <= `SSP_BITS_PER_XFER) else $error("more than eight clocks counted");

    a_sys_clock_len: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (q.clksel == ssp_pkg::SSP_CLK_SYS && $rose(q.go) && q.st == ssp_pkg::SSP_ST_IDLE)
        |-> ##18 shift_done_irq_o) else $error("system clock transfer length wrong");

    a_irq_level: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        shift_done_irq_o |=> q.irq_stat) else $error("status not set by completion");

    a_slave_release: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !master |=> !sclk_pin_oe_o || $changed(q.clksel)) else $error("slave still driving clock");

    a_start_count: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (q.st == ssp_pkg::SSP_ST_IDLE && q.go) |=> (q.cnt == 4'h0 && q.st != ssp_pkg::SSP_ST_IDLE))
        else $error("transfer did not start from a clear count");

    a_slave_rise_count: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (!master && q.st == ssp_pkg::SSP_ST_LOW && q.cnt != `SSP_BITS_PER_XFER && ext_rise)
        |=> q.cnt == $past(q.cnt) + 4'h1) else $error("slave rising edge not counted");

    a_idle_out_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (q.st == ssp_pkg::SSP_ST_IDLE && !q.go) |=> $stable(serial_out_pin_o))
        else $error("data pin moved between transfers");

endmodule

/* File: tb/ssp_partner.sv */
/*
 * Far-side device model of the shift port: sends one byte, captures one.
 * Assumes the bench resolves the shift-clock wire and arms it per frame.
 */
`timescale 1ns/1ps
module ssp_partner (
    // Link
    input wire logic sclk_i,
    input wire logic serial_out_pin_i,
    output logic sin_o,
    output logic sclk_o,
    // Bench control
    input wire logic arm_i,
    input wire logic lsb_first_i,
    input wire logic [7:0] tx_i,
    output logic [7:0] rx_o
);
    int fall_cnt = 0;
    int rise_cnt = 0;
    initial sin_o = 1'h0;
    initial sclk_o = 1'h1;
    initial rx_o = 8'h00;
    always @(posedge arm_i) begin
        fall_cnt = 0;
        rise_cnt = 0;
    end
    // Outside a frame each falling edge inverts the line, so it carries junk
    always @(negedge sclk_i) begin
        if (arm_i && fall_cnt < 8) begin
            sin_o = tx_i[lsb_first_i ? fall_cnt : 7 - fall_cnt];
        end else begin
            sin_o = ~sin_o;
        end
        fall_cnt++;
    end
    always @(posedge sclk_i) begin
        if (arm_i && rise_cnt < 8) begin
            rx_o[lsb_first_i ? rise_cnt : 7 - rise_cnt] = serial_out_pin_i;
            rise_cnt++;
        end
    end
    // Slave-mode clock, 125 ns period, standing high between frames
    task automatic gen_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            #62.5 sclk_o = 1'h0;
            #62.5 sclk_o = 1'h1;
        end
    endtask
endmodule

/* File: tb/tb_top.sv */
/*
 * Self-checking bench of the shift port over AXI4-Lite and the serial pins.
 * Assumes the far device model and the register index header.
 */
`timescale 1ns/1ps
`include "ssp_regs.svh"
module tb_top;
    logic clk_i, sys_rst_i, awv, wv, brdy, arv, rrdy;
    logic tmr = 1'h0;
    logic [11:0] awa, ara;
    logic [31:0] wd, rd;
    logic awr, wr_, bv, arr, rv, serial_out_pin, sck, sck_oe, dirq, irq, serial_in_pin, psck, arm, lsb;
    logic [1:0] br, rr;
    logic [1:0] tcnt = 2'h0;
    logic [7:0] ptx, prx;
    wire sck_w = sck_oe ? sck : psck;
    int failures = 0;
    int comparisons = 0;
    int cyc = 0;
    int falls = 0;
    int pulses = 0;
    ssp_shift_port #(.ADDR_W(12)) ssp_shift_port_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_), .s_axi_bresp_o(br),
        .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rrdy), .tmr_ovf_i(tmr), .serial_in_pin_i(serial_in_pin), .serial_out_pin_o(serial_out_pin),
        .sclk_pin_i(sck_w), .sclk_pin_o(sck), .sclk_pin_oe_o(sck_oe), .shift_done_irq_o(dirq),
        .irq_o(irq));
    ssp_partner ssp_partner_inst (.sclk_i(sck_w), .serial_out_pin_i(serial_out_pin), .sin_o(serial_in_pin), .sclk_o(psck),
        .arm_i(arm), .lsb_first_i(lsb), .tx_i(ptx), .rx_o(prx));
    // ==========================================
    // Clock, timer and monitors
    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end
    always @(negedge sck_w) falls++;
    always @(posedge clk_i) begin
        tcnt <= tcnt + 2'h1;
        tmr <= (tcnt == 2'h3);
        if (dirq === 1'h1) pulses++;
        cyc++;
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
    end
    // ==========================================
    // Shared tasks
    task wrap_up;
        if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic axi_wr(input logic [11:0] idx, input logic [31:0] d, output logic [1:0] r);
        r = 2'h3;
        @(posedge clk_i);
        awa <= {idx[9:0], 2'h0};
        awv <= 1'h1;
        wd <= d;
        wv <= 1'h1;
        brdy <= 1'h1;
        forever begin
            @(posedge clk_i);
            if (awv && awr) awv <= 1'h0;
            if (wv && wr_) wv <= 1'h0;
            if (brdy && bv) begin
                r = br;
                brdy <= 1'h0;
                break;
            end
        end
    endtask
    task automatic axi_rd(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
        r = 2'h3;
        @(posedge clk_i);
        ara <= {idx[9:0], 2'h0};
        arv <= 1'h1;
        rrdy <= 1'h1;
        forever begin
            @(posedge clk_i);
            if (arv && arr) arv <= 1'h0;
            if (rrdy && rv) begin
                d = rd;
                r = rr;
                rrdy <= 1'h0;
                break;
            end
        end
    endtask
    task automatic reg_wr(input logic [11:0] idx, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(idx, d, r);
        check("bresp", r, 32'h0);
    endtask
    task automatic reg_chk(input string name, input logic [11:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(idx, d, r);
        check("rresp", r, 32'h0);
        check(name, d, exp);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 4; i++) reg_chk("reset_reg", 12'h0A0 + 12'(i), 32'h0);
        check("sclk_rst", sck_w, 32'h1);
        check("serial_out_pin_rst", serial_out_pin, 32'h0);
        axi_rd(12'h0B0, d, r);
        check("rresp_unmapped", r, 32'h2);
        axi_wr(12'h0B0, 32'h5, r);
        check("bresp_unmapped", r, 32'h2);
    endtask
    task automatic t_xfer(input logic [1:0] sel, input logic ord, input logic [7:0] tx,
        input logic [7:0] rx, input logic m);
        int f0;
        int p0;
        logic [31:0] d;
        logic [1:0] r;
        reg_wr(`SSP_IDX_CTRL_A, {29'h0, ord, sel});
        reg_wr(`SSP_IDX_DATA_LOW, {28'h0, tx[3:0]});
        reg_wr(`SSP_IDX_DATA_HIGH, {28'h0, tx[7:4]});
        reg_wr(`SSP_IDX_IRQ_MASK, {31'h0, m});
        ptx = rx;
        lsb = ord;
        arm = 1'h1;
        check("sclk_drive", sck_oe, sel != ssp_pkg::SSP_CLK_EXT);
        f0 = falls;
        p0 = pulses;
        reg_wr(`SSP_IDX_CTRL_B, 32'h1);
        if (sel == ssp_pkg::SSP_CLK_EXT) ssp_partner_inst.gen_clocks(9);
        d = 32'h1;
        for (int i = 0; i < 200 && d[0]; i++) axi_rd(`SSP_IDX_CTRL_B, d, r);
        check("go_cleared", d[0], 32'h0);
        check("far_rx", prx, tx);
        reg_chk("rx_low", `SSP_IDX_DATA_LOW, rx[3:0]);
        reg_chk("rx_high", `SSP_IDX_DATA_HIGH, rx[7:4]);
        reg_chk("irq_status", `SSP_IDX_IRQ_STATUS, 32'h1);
        check("irq_level", irq, m);
        check("done_pulses", pulses - p0, 32'h1);
        if (sel != ssp_pkg::SSP_CLK_EXT) check("clk_falls", falls - f0, 32'h8);
        check("sclk_idle", sck_w, 32'h1);
        check("serial_out_pin_hold", serial_out_pin, ord ? tx[7] : tx[0]);
        reg_wr(`SSP_IDX_IRQ_STATUS, 32'h1);
        reg_chk("irq_clear", `SSP_IDX_IRQ_STATUS, 32'h0);
        check("irq_low", irq, 32'h0);
        arm = 1'h0;
    endtask
    task automatic t_no_go;
        reg_wr(`SSP_IDX_CTRL_A, 32'h3);
        reg_wr(`SSP_IDX_DATA_LOW, 32'hC);
        reg_wr(`SSP_IDX_DATA_HIGH, 32'h3);
        ptx = 8'hFF;
        arm = 1'h1;
        ssp_partner_inst.gen_clocks(8);
        repeat (8) @(posedge clk_i);
        reg_chk("hold_low", `SSP_IDX_DATA_LOW, 32'hC);
        reg_chk("hold_high", `SSP_IDX_DATA_HIGH, 32'h3);
        reg_chk("no_irq", `SSP_IDX_IRQ_STATUS, 32'h0);
        arm = 1'h0;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        sys_rst_i = 1'h1;
        {awv, wv, brdy, arv, rrdy, arm, lsb} = 7'h00;
        awa = 12'h000;
        ara = 12'h000;
        wd = 32'h0;
        ptx = 8'h00;
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'h0;
        t_reset();
        t_xfer(2'h0, 1'h0, 8'hA3, 8'h5C, 1'h1);
        t_xfer(2'h1, 1'h1, 8'h1E, 8'hC4, 1'h0);
        t_xfer(2'h2, 1'h0, 8'h6B, 8'h92, 1'h1);
        t_xfer(2'h3, 1'h1, 8'hD4, 8'h27, 1'h1);
        t_xfer(2'h3, 1'h0, 8'h0E, 8'hF1, 1'h0);
        t_no_go();
        wrap_up();
    end
endmodule
